// file: src/mcm_defines.svh
// Constants of the main clock fail monitor: addresses, bits, counts.
// Assumes inclusion by bare name from package and modules.
`ifndef MCM_DEFINES_SVH
`define MCM_DEFINES_SVH
`define MCM_ADDR_CTRL 32'hfffff870
`define MCM_ADDR_PROT 32'hfffff874
`define MCM_ADDR_CAUSE 32'hfffff878
`define MCM_ADDR_STAT 32'hfffff87c
`define MCM_ADDR_OSC 32'hfffff880
`define MCM_ADDR_FWLO 32'hfffff884
`define MCM_ADDR_FWHI 32'hfffff888
`define MCM_PROT_KEY 8'ha5
`define MCM_KEY_W 8
`define MCM_EN_BIT 0
`define MCM_OSC_STOP_BIT 0
`define MCM_CAUSE_WDT 0
`define MCM_CAUSE_CLK 1
`define MCM_CAUSE_LVI 2
`define MCM_STAT_WATCH 0
`define MCM_STAT_PAUSE 1
`define MCM_STAT_RESET 2
`define MCM_STAT_RUN 3
`define MCM_STAT_HOLD 4
`define MCM_FAIL_W 8
`define MCM_FAIL_LAST 8'h3f
`define MCM_HOLD_W 4
`define MCM_HOLD_LAST 4'h7
`define MCM_STAB_W 17
`define MCM_STAB_DEFAULT 65536
`define MCM_FW_RAM_LO 32'h03ffefba
`define MCM_FW_RAM_HI 32'h03ffefff
`endif

// file: src/mcm_pkg.sv
// Types of the main clock fail monitor.
// Assumes mcm_defines.svh on the include path.
`include "mcm_defines.svh"
package mcm_pkg;
  typedef enum logic [1:0] {MCM_OFF, MCM_WATCH, MCM_PAUSE, MCM_RESET} mcm_mon_state_t;

  typedef struct packed {
    logic [1:0] q;
  } mcm_sync_t;

  typedef struct packed {
    logic last;
    logic [`MCM_FAIL_W-1:0] cnt;
    logic rise;
    logic fail;
  } mcm_watch_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic enable;
    logic armed;
    logic flag_wdt;
    logic flag_clk;
    logic flag_lvi;
    logic main_hold;
    logic int_osc_stop;
    logic sys_reset_req;
    logic [`MCM_HOLD_W-1:0] hold_cnt;
    logic [`MCM_STAB_W-1:0] stab_cnt;
    logic cpu_run;
    mcm_mon_state_t mstate;
  } mcm_core_t;
endpackage

// file: src/mcm_sync.sv
// Two-stage synchroniser for one level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`include "mcm_defines.svh"
module mcm_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic din,
  output logic dout
);
  mcm_pkg::mcm_sync_t st;
  mcm_pkg::mcm_sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.q = {st.q[0], din};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.q[1];
endmodule

// file: src/mcm_edge_watch.sv
// Main clock stop detector on the sampling clock.
// Assumes a synchronised main clock level, slower than clk/2.
`timescale 1ns/1ps
`include "mcm_defines.svh"
module mcm_edge_watch (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic level,
  input wire logic check,
  output logic rise,
  output logic fail
);
  mcm_pkg::mcm_watch_t st;
  mcm_pkg::mcm_watch_t next_st;

  always_comb begin
    next_st = st;
    next_st.last = level;
    next_st.rise = level & ~st.last;
    next_st.fail = 1'b0;
    // Any edge restarts the silence count
    if (!check || level != st.last) begin
      next_st.cnt = '0;
    end else if (st.cnt == `MCM_FAIL_LAST) begin
      next_st.fail = 1'b1;
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + `MCM_FAIL_W'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise = st.rise;
  assign fail = st.fail;
endmodule

// file: src/mcm_main_clock_fail_monitor.sv
// Main clock fail monitor: Wishbone register slave, stop detection,
// suspension, reset request, reset cause flags, start-up settling.
// Assumes ref_clk is the internal oscillator clock; mode inputs are
// produced by logic on ref_clk; main_clk is an asynchronous pin.
//
// Contract
// - Sample main clock, request reset on stop
// - Enable bit set-only until reset
// - Monitor reset clears enable, sets its flag
// - Control register eight bits, reset zero, byte access
// - Enable at bit zero, upper bits zero
// - Control writes only through protected sequence
// - Suspend in STOP and settling, then resume
// - Suspend from main stop until main selected
// - Suspend while internal oscillator stopped
// - No checking while CPU on internal oscillator
// - Check in idle modes, stop in STOP/reset
// - Pin reset clears enable; software write starts
// - Pin reset clears flags; others set own
// - Ignore internal oscillator stop while CPU uses it
// - Firmware RAM region not kept over power-on
// - Wait settling main periods before CPU runs
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`include "mcm_defines.svh"
module mcm_main_clock_fail_monitor #(
  parameter int unsigned STAB_CYCLES = `MCM_STAB_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [31:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic main_clk,
  input wire logic stop_mode,
  input wire logic osc_settling,
  input wire logic main_osc_stop_bit,
  input wire logic cpu_clock_select_status,
  input wire logic cpu_on_internal_osc_flag,
  input wire logic wdt_reset_req,
  input wire logic lvi_reset_req,
  output logic sys_reset_req,
  output logic internal_osc_stop_bit,
  output logic cpu_run_enable,
  output mcm_pkg::mcm_mon_state_t monitor_state
);
  localparam logic [`MCM_STAB_W-1:0] STAB_LAST = `MCM_STAB_W'(STAB_CYCLES - 1);

  mcm_pkg::mcm_core_t st;
  mcm_pkg::mcm_core_t next_st;
  logic main_lvl;
  logic main_rise;
  logic wd_fail;
  logic checking;
  logic clk_fail;
  logic sysrst;
  logic req;
  logic wr_any;
  logic wr;
  logic [31:0] rd;

  //////////////////////////////////////////////////////////////////////
  // Main clock sampling
  mcm_sync u_sync (
    .clk(ref_clk),
    .reset_n(reset_n),
    .din(main_clk),
    .dout(main_lvl)
  );

  mcm_edge_watch u_watch (
    .clk(ref_clk),
    .reset_n(reset_n),
    .level(main_lvl),
    .check(checking),
    .rise(main_rise),
    .fail(wd_fail)
  );

  //////////////////////////////////////////////////////////////////////
  // Suspension and failure
  always_comb begin
    checking = st.enable
      & ~st.sys_reset_req
      & ~stop_mode & ~osc_settling
      & ~st.main_hold & ~main_osc_stop_bit
      & ~st.int_osc_stop
      & ~cpu_on_internal_osc_flag;
    clk_fail = wd_fail & checking;
    sysrst = clk_fail | wdt_reset_req | lvi_reset_req;
  end

  //////////////////////////////////////////////////////////////////////
  // Register file and control state
  always_comb begin
    next_st = st;
    req = wb_cyc & wb_stb & ~st.ack;
    wr_any = req & wb_we;
    wr = wr_any & wb_sel[0];
    rd = 32'h0;
    unique case (wb_adr)
      `MCM_ADDR_CTRL: rd[`MCM_EN_BIT] = st.enable;
      `MCM_ADDR_CAUSE: begin
        rd[`MCM_CAUSE_WDT] = st.flag_wdt;
        rd[`MCM_CAUSE_CLK] = st.flag_clk;
        rd[`MCM_CAUSE_LVI] = st.flag_lvi;
      end
      `MCM_ADDR_STAT: begin
        rd[`MCM_STAT_WATCH] = st.mstate == mcm_pkg::MCM_WATCH;
        rd[`MCM_STAT_PAUSE] = st.mstate == mcm_pkg::MCM_PAUSE;
        rd[`MCM_STAT_RESET] = st.mstate == mcm_pkg::MCM_RESET;
        rd[`MCM_STAT_RUN] = st.cpu_run;
        rd[`MCM_STAT_HOLD] = st.main_hold;
      end
      `MCM_ADDR_OSC: rd[`MCM_OSC_STOP_BIT] = st.int_osc_stop;
      `MCM_ADDR_FWLO: rd = `MCM_FW_RAM_LO;
      `MCM_ADDR_FWHI: rd = `MCM_FW_RAM_HI;
      default: rd = 32'h0;
    endcase
    next_st.ack = req;
    next_st.rdata = (req && !wb_we) ? rd : 32'h0;

    // Key arms exactly one following write
    if (wr_any) begin
      next_st.armed = wr && wb_adr == `MCM_ADDR_PROT && wb_dat_w[`MCM_KEY_W-1:0] == `MCM_PROT_KEY;
    end
    if (wr && wb_adr == `MCM_ADDR_CTRL && st.armed) begin
      next_st.enable = st.enable | wb_dat_w[`MCM_EN_BIT];
    end
    if (wr && wb_adr == `MCM_ADDR_OSC && !cpu_on_internal_osc_flag) begin
      next_st.int_osc_stop = wb_dat_w[`MCM_OSC_STOP_BIT];
    end

    // Deliberate main stop held until main clock reselected
    if (main_osc_stop_bit) begin
      next_st.main_hold = 1'b1;
    end else if (!cpu_clock_select_status) begin
      next_st.main_hold = 1'b0;
    end

    // Reset request pulse length
    if (st.sys_reset_req) begin
      if (st.hold_cnt == '0) begin
        next_st.sys_reset_req = 1'b0;
      end else begin
        next_st.hold_cnt = st.hold_cnt - `MCM_HOLD_W'(1);
      end
    end

    // Start-up settling in main clock periods
    if (!st.cpu_run && main_rise) begin
      if (st.stab_cnt == STAB_LAST) begin
        next_st.cpu_run = 1'b1;
      end else begin
        next_st.stab_cnt = st.stab_cnt + `MCM_STAB_W'(1);
      end
    end

    // System resets: own flag set, others kept
    if (sysrst) begin
      next_st.enable = 1'b0;
      next_st.armed = 1'b0;
      next_st.int_osc_stop = 1'b0;
      next_st.stab_cnt = '0;
      next_st.cpu_run = 1'b0;
    end
    if (clk_fail) begin
      next_st.flag_clk = 1'b1;
      next_st.sys_reset_req = 1'b1;
      next_st.hold_cnt = `MCM_HOLD_LAST;
    end
    if (wdt_reset_req) begin
      next_st.flag_wdt = 1'b1;
    end
    if (lvi_reset_req) begin
      next_st.flag_lvi = 1'b1;
    end

    if (next_st.sys_reset_req) begin
      next_st.mstate = mcm_pkg::MCM_RESET;
    end else if (!st.enable) begin
      next_st.mstate = mcm_pkg::MCM_OFF;
    end else if (checking) begin
      next_st.mstate = mcm_pkg::MCM_WATCH;
    end else begin
      next_st.mstate = mcm_pkg::MCM_PAUSE;
    end
  end

  // Pin reset clears enable and all cause flags
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack = st.ack;
  assign wb_dat_r = st.rdata;
  assign sys_reset_req = st.sys_reset_req;
  assign internal_osc_stop_bit = st.int_osc_stop;
  assign cpu_run_enable = st.cpu_run;
  assign monitor_state = st.mstate;

  //////////////////////////////////////////////////////////////////////
  // Checks
  property p_reset_pulse;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(st.sys_reset_req) |-> st.sys_reset_req[*8] ##1 !st.sys_reset_req;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset request not eight cycles");

  property p_set_only;
    @(posedge ref_clk) disable iff (!reset_n)
      $fell(st.enable) |-> $past(sysrst);
  endproperty
  a_set_only: assert property (p_set_only) else $error("enable cleared without reset");

  property p_fail_effect;
    @(posedge ref_clk) disable iff (!reset_n)
      clk_fail |=> st.flag_clk && !st.enable && st.sys_reset_req;
  endproperty
  a_fail_effect: assert property (p_fail_effect) else $error("failure did not flag and clear");

  property p_ctrl_read;
    @(posedge ref_clk) disable iff (!reset_n)
      req && !wb_we && wb_adr == `MCM_ADDR_CTRL |=> wb_ack && wb_dat_r[31:1] == 31'h0
        && wb_dat_r[0] == $past(st.enable);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

  property p_unprotected;
    @(posedge ref_clk) disable iff (!reset_n)
      wr && wb_adr == `MCM_ADDR_CTRL && !st.armed && !sysrst |=> st.enable == $past(st.enable);
  endproperty
  a_unprotected: assert property (p_unprotected) else $error("plain write changed enable");

  property p_stop_pause;
    @(posedge ref_clk) disable iff (!reset_n)
      st.enable && (stop_mode || osc_settling) && !sysrst |=> st.mstate == mcm_pkg::MCM_PAUSE;
  endproperty
  a_stop_pause: assert property (p_stop_pause) else $error("checking during stop");

  property p_main_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      main_osc_stop_bit ##1 cpu_clock_select_status |-> st.main_hold && !checking;
  endproperty
  a_main_hold: assert property (p_main_hold) else $error("main stop not held");

  property p_int_osc;
    @(posedge ref_clk) disable iff (!reset_n)
      st.int_osc_stop || cpu_on_internal_osc_flag |-> !checking;
  endproperty
  a_int_osc: assert property (p_int_osc) else $error("checking on internal oscillator");

  property p_osc_ignore;
    @(posedge ref_clk) disable iff (!reset_n)
      wr && wb_adr == `MCM_ADDR_OSC && cpu_on_internal_osc_flag && !sysrst
        |=> st.int_osc_stop == $past(st.int_osc_stop);
  endproperty
  a_osc_ignore: assert property (p_osc_ignore) else $error("oscillator stop not ignored");

  property p_flags_keep;
    @(posedge ref_clk) disable iff (!reset_n)
      wdt_reset_req && !clk_fail && !lvi_reset_req |=> st.flag_wdt
        && st.flag_clk == $past(st.flag_clk) && st.flag_lvi == $past(st.flag_lvi);
  endproperty
  a_flags_keep: assert property (p_flags_keep) else $error("watchdog reset disturbed flags");

  property p_settle;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(st.cpu_run) |-> $past(main_rise) && $past(st.stab_cnt) == STAB_LAST;
  endproperty
  a_settle: assert property (p_settle) else $error("CPU released early");

  property p_ack_pulse;
    @(posedge ref_clk) disable iff (!reset_n)
      wb_ack |=> !wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge longer than one cycle");

  property p_cause_read;
    @(posedge ref_clk) disable iff (!reset_n)
      req && !wb_we && wb_adr == `MCM_ADDR_CAUSE |=> wb_dat_r[`MCM_CAUSE_WDT] == $past(st.flag_wdt)
        && wb_dat_r[`MCM_CAUSE_CLK] == $past(st.flag_clk) && wb_dat_r[`MCM_CAUSE_LVI] == $past(st.flag_lvi);
  endproperty
  a_cause_read: assert property (p_cause_read) else $error("cause read wrong");

  property p_enable_write;
    @(posedge ref_clk) disable iff (!reset_n)
      wr && wb_adr == `MCM_ADDR_CTRL && st.armed && wb_dat_w[`MCM_EN_BIT] && !sysrst
        |=> st.enable;
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("protected write did not enable");

  property p_flags_lvi;
    @(posedge ref_clk) disable iff (!reset_n)
      lvi_reset_req && !clk_fail && !wdt_reset_req |=> st.flag_lvi
        && st.flag_clk == $past(st.flag_clk) && st.flag_wdt == $past(st.flag_wdt);
  endproperty
  a_flags_lvi: assert property (p_flags_lvi) else $error("low voltage reset disturbed flags");

  property p_flags_clk;
    @(posedge ref_clk) disable iff (!reset_n)
      clk_fail && !wdt_reset_req && !lvi_reset_req |=> st.flag_clk
        && st.flag_wdt == $past(st.flag_wdt) && st.flag_lvi == $past(st.flag_lvi);
  endproperty
  a_flags_clk: assert property (p_flags_clk) else $error("clock fail reset disturbed flags");

  property p_main_stop;
    @(posedge ref_clk) disable iff (!reset_n)
      main_osc_stop_bit |-> !checking;
  endproperty
  a_main_stop: assert property (p_main_stop) else $error("checking with main stopped");

  property p_hold_release;
    @(posedge ref_clk) disable iff (!reset_n)
      !main_osc_stop_bit && !cpu_clock_select_status |=> !st.main_hold;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("main hold not released");

  property p_sample_stop;
    @(posedge ref_clk) disable iff (!reset_n)
      st.int_osc_stop |-> !checking && !clk_fail;
  endproperty
  a_sample_stop: assert property (p_sample_stop) else $error("checking with sampling clock stopped");

  property p_watch_state;
    @(posedge ref_clk) disable iff (!reset_n)
      checking && !sysrst |=> monitor_state == mcm_pkg::MCM_WATCH;
  endproperty
  a_watch_state: assert property (p_watch_state) else $error("status not watching");

  property p_osc_write;
    @(posedge ref_clk) disable iff (!reset_n)
      wr && wb_adr == `MCM_ADDR_OSC && !cpu_on_internal_osc_flag && !sysrst
        |=> st.int_osc_stop == $past(wb_dat_w[`MCM_OSC_STOP_BIT]);
  endproperty
  a_osc_write: assert property (p_osc_write) else $error("oscillator stop write lost");

  property p_settle_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      !st.cpu_run && !main_rise |=> !st.cpu_run;
  endproperty
  a_settle_hold: assert property (p_settle_hold) else $error("CPU released without main edge");
endmodule

// file: tb/mcm_tb_main_osc.sv
// Behavioural main oscillator facing the clock fail monitor.
// Assumes run comes from the bench; a stopped oscillator holds its level.
`timescale 1ns/1ps
module mcm_tb_main_osc #(
  parameter int HALF_NS = 10
) (
  input wire logic run,
  output logic main_clk
);
  initial main_clk = 1'h0;
  always begin
    #(HALF_NS);
    if (run) main_clk = ~main_clk;
  end
endmodule

// file: tb/test_main_clock_fail_monitor.sv
// Self-checking bench of the main clock fail monitor.
// Assumes the design package, defines header and oscillator model.
`timescale 1ns/1ps
`include "mcm_defines.svh"
module test_main_clock_fail_monitor;
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  logic wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0, run = 1'h1, rst_seen = 1'h0;
  logic [31:0] wb_adr = 32'h0, wb_dat_w = 32'h0, wb_dat_r, rd;
  logic [3:0] wb_sel = 4'h1;
  logic [4:0] mode = 5'h0;
  logic [1:0] req = 2'h0;
  logic wb_ack, main_clk, sys_reset_req, osc_stop, cpu_run;
  mcm_pkg::mcm_mon_state_t mstate;
  int errors = 0, check_count = 0;
  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (sys_reset_req === 1'h1) rst_seen <= 1'h1;
  mcm_tb_main_osc osc_u (.run(run), .main_clk(main_clk));
  mcm_main_clock_fail_monitor #(.STAB_CYCLES(16)) dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .main_clk(main_clk), .stop_mode(mode[0]), .osc_settling(mode[1]), .main_osc_stop_bit(mode[2]),
    .cpu_clock_select_status(mode[3]), .cpu_on_internal_osc_flag(mode[4]),
    .wdt_reset_req(req[0]), .lvi_reset_req(req[1]), .sys_reset_req(sys_reset_req),
    .internal_osc_stop_bit(osc_stop), .cpu_run_enable(cpu_run), .monitor_state(mstate));
  ////////////////////////////////////////
  task automatic print_verdict();
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic timeout(string name);
    chk(name, 32'h1, 32'h0);
    print_verdict();
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wb(logic we, logic [31:0] adr, logic [31:0] dat);
    int i;
    @(posedge ref_clk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= dat;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (wb_ack === 1'h1) break;
    end
    if (i == 20) timeout("wb_ack");
    rd = wb_dat_r;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
  endtask
  task automatic rchk(string name, logic [31:0] adr, logic [31:0] exp);
    wb(1'h0, adr, 32'h0);
    chk(name, rd, exp);
  endtask
  // Key write arms only the next write
  task automatic kw(logic [31:0] adr, logic [31:0] dat);
    wb(1'h1, `MCM_ADDR_PROT, 32'ha5);
    wb(1'h1, adr, dat);
  endtask
  task automatic pulse(logic [1:0] v);
    req <= v;
    cyc(1);
    req <= 2'h0;
    cyc(2);
  endtask
  ////////////////////////////////////////
  task automatic t_settle();
    int i;
    for (i = 0; i < 400 && cpu_run !== 1'h1; i++) @(negedge ref_clk);
    if (i == 400) timeout("cpu_run");
    // Sixteen main periods span at least 75 sampling cycles
    chk("settle_early", i >= 70, 1'h1);
  endtask
  task automatic t_enable();
    rchk("ctrl_reset", `MCM_ADDR_CTRL, 32'h0);
    rchk("cause_reset", `MCM_ADDR_CAUSE, 32'h0);
    rchk("unmapped", 32'hfffff8f0, 32'h0);
    wb(1'h1, `MCM_ADDR_CTRL, 32'h1);
    rchk("plain_write", `MCM_ADDR_CTRL, 32'h0);
    kw(`MCM_ADDR_CTRL, 32'hff);
    rchk("ctrl_bits", `MCM_ADDR_CTRL, 32'h1);
    kw(`MCM_ADDR_CTRL, 32'h0);
    rchk("set_only", `MCM_ADDR_CTRL, 32'h1);
    cyc(4);
    chk("watch", mstate, mcm_pkg::MCM_WATCH);
  endtask
  // Each suspension source hides a stopped main clock
  task automatic t_pause();
    logic [4:0] m [4] = '{5'h01, 5'h02, 5'h0c, 5'h10};
    for (int k = 0; k < 5; k++) begin
      rst_seen <= 1'h0;
      if (k < 4) mode <= m[k];
      else wb(1'h1, `MCM_ADDR_OSC, 32'h1);
      cyc(2);
      if (k == 4) chk("osc_stop_pin", osc_stop, 1'h1);
      run = 1'h0;
      cyc(120);
      run = 1'h1;
      cyc(10);
      if (k < 4) mode <= 5'h0;
      else wb(1'h1, `MCM_ADDR_OSC, 32'h0);
      cyc(10);
      chk("paused", rst_seen, 1'h0);
      chk("resumed", mstate, mcm_pkg::MCM_WATCH);
    end
    mode <= 5'h10;
    cyc(1);
    wb(1'h1, `MCM_ADDR_OSC, 32'h1);
    rchk("osc_stop_ignored", `MCM_ADDR_OSC, 32'h0);
    chk("osc_stop_kept", osc_stop, 1'h0);
    mode <= 5'h0;
    wb_sel <= 4'he;
    wb(1'h1, `MCM_ADDR_OSC, 32'h1);
    wb_sel <= 4'h1;
    rchk("sel_refused", `MCM_ADDR_OSC, 32'h0);
  endtask
  task automatic t_fail();
    int i;
    int n;
    mode <= 5'h08;
    cyc(4);
    chk("sub_idle_watch", mstate, mcm_pkg::MCM_WATCH);
    run = 1'h0;
    for (i = 0; i < 300 && sys_reset_req !== 1'h1; i++) @(negedge ref_clk);
    if (i == 300) timeout("sys_reset_req");
    // Silence limit of 64 cycles plus sync and register stages
    chk("fail_time", i >= 60 && i <= 80, 1'h1);
    n = 0;
    do begin
      n++;
      @(negedge ref_clk);
    end while (sys_reset_req === 1'h1 && n < 20);
    chk("reset_width", n, 8);
    run = 1'h1;
    mode <= 5'h0;
    rchk("ctrl_cleared", `MCM_ADDR_CTRL, 32'h0);
    rchk("cause_clk", `MCM_ADDR_CAUSE, 32'h2);
  endtask
  task automatic t_causes();
    pulse(2'h1);
    rchk("cause_wdt", `MCM_ADDR_CAUSE, 32'h3);
    pulse(2'h2);
    rchk("cause_lvi", `MCM_ADDR_CAUSE, 32'h7);
    kw(`MCM_ADDR_CTRL, 32'h1);
    reset_n <= 1'h0;
    cyc(3);
    reset_n <= 1'h1;
    rchk("cause_pin", `MCM_ADDR_CAUSE, 32'h0);
    rchk("ctrl_pin", `MCM_ADDR_CTRL, 32'h0);
    chk("state_pin", mstate, mcm_pkg::MCM_OFF);
    rchk("fw_lo", `MCM_ADDR_FWLO, 32'h03ffefba);
    rchk("fw_hi", `MCM_ADDR_FWHI, 32'h03ffefff);
  endtask
  ////////////////////////////////////////
  initial begin
    cyc(12);
    reset_n <= 1'h1;
    @(negedge ref_clk);
    chk("cpu_run_early", cpu_run, 1'h0);
    chk("state_off", mstate, mcm_pkg::MCM_OFF);
    t_settle();
    t_enable();
    t_pause();
    t_fail();
    t_causes();
    print_verdict();
  end
endmodule
